/* logic/ssp_serial_port.sv */
// ssp_serial_port: synchronous serial port, master or slave, apb slave.
// assumes: one 100 MHz clock, synchronous reset; serial pins come from
// outside and are synchronised here.
//
// Functional notes
// - transmit and receive each own an independent 16-bit, 8-deep fifo.
// - dma requests appear only when their dma control bits are set.
// - first divider stage divides by an even prescale from 2 to 254.
// - second stage divides by rate factor plus one, 1 to 256.
// - data write pushes transmit fifo; data read pops receive fifo.
// - slave shifts a frame whenever the master starts one.
// - slave with empty fifo sends eighth most recent write, else zero.
// - empty transmit fifo can raise interrupt or dma request.
// - received bits collect in a shift register, then load the fifo.
// - transmit service active while transmit fifo holds four or fewer.
// - receive service active while receive fifo holds four or more.
// - all five sources are ored into one combined request.
// - a source reaches the interrupt outputs only while its mask bit is set; dma requests ignore the mask.
// - data-flow interrupts are output apart from status interrupts.
// - raw and masked interrupt states read from separate registers.
// - time-out after 32 bit periods of non-empty receive fifo.
// - end of transmission flags when all data has been shifted out.
// - frames carry 4 to 16 bits, most significant bit first.
// - frame format selects spi or synchronous frame-pulse format.
// - serial clock idles inactive, toggles only during a frame.
`timescale 1ns/10ps
module ssp_serial_port (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial pins
  output logic             serialBitClockOut,
  input  wire logic        serialBitClockIn,
  output logic             frameOut,
  input  wire logic        frameIn,
  output logic             serialOutLine,
  output logic             serialOutEnN,
  input  wire logic        serialInLine,
  // interrupts and dma
  output logic             irqCombined,
  output logic             irqTxService,
  output logic             irqRxService,
  output logic             irqStatus,
  output logic             txDmaReq,
  output logic             rxDmaReq
);

  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} ssp_state_t;

  ssp_pkg::ssp_ctrl0_t ctrl0_r;
  ssp_pkg::ssp_irq_t   imask_r;
  ssp_pkg::ssp_irq_t   raw;
  ssp_pkg::ssp_irq_t   masked;
  ssp_state_t          state_r;
  logic [1:0]          ctrl1_r;
  logic [7:0]          prescale_r;
  logic [1:0]          dmaCtl_r;
  logic                rtRaw_r;
  logic                rorRaw_r;
  logic                eotRaw_r;
  // apb
  logic                setupPh;
  logic                accessPh;
  logic                wrEn;
  logic                mapped;
  logic [31:0]         rdMux;
  // fifos
  logic                txPush;
  logic                txPop;
  logic [15:0]         txHead;
  logic [3:0]          txCount;
  logic                txFull;
  logic                txEmpty;
  logic [15:0]         txStale;
  logic                rxPush;
  logic                rxPop;
  logic [15:0]         rxHead;
  logic [3:0]          rxCount;
  logic                rxFull;
  logic                rxEmpty;
  logic [15:0]         rxWord;
  // divider
  logic [6:0]          preCnt_r;
  logic [6:0]          preHalf;
  logic                preTick;
  logic [7:0]          rateCnt_r;
  logic                halfTick;
  logic                halfPhase_r;
  logic                bitTick;
  // synchronisers
  logic [1:0]          sclkSync_r;
  logic [1:0]          frmSync_r;
  logic [1:0]          rxdSync_r;
  logic                sclkPrev_r;
  logic                frmPrev_r;
  // engine
  logic                enabled;
  logic                isSlave;
  logic [3:0]          sizeM1;
  logic                cpha;
  logic                idleClk;
  logic                slaveStart;
  logic                masterStart;
  logic                startEv;
  logic                edgeEv;
  logic                sampleEv;
  logic                shiftEv;
  logic                lastEdge;
  logic                frameDone;
  logic                slaveAbort;
  logic [4:0]          edgeCnt_r;
  logic [15:0]         txShift_r;
  logic [15:0]         rxShift_r;
  logic [15:0]         sizeMask;
  logic [15:0]         loadWord;
  logic [5:0]          rtCnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // fifos
  ssp_fifo u_txFifo (
    .mclk      (mclk),
    .rst       (rst),
    .push      (txPush),
    .pushData  (pwdata[15:0]),
    .pop       (txPop),
    .headData  (txHead),
    .count     (txCount),
    .full      (txFull),
    .empty     (txEmpty),
    .staleWord (txStale)
  );

  ssp_fifo u_rxFifo (
    .mclk      (mclk),
    .rst       (rst),
    .push      (rxPush),
    .pushData  (rxWord),
    .pop       (rxPop),
    .headData  (rxHead),
    .count     (rxCount),
    .full      (rxFull),
    .empty     (rxEmpty),
    .staleWord ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode, one wait-free access phase
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable && pready;
  assign wrEn     = accessPh && pwrite && !pslverr;
  assign txPush   = wrEn && paddr == ssp_pkg::DATA_OFS;
  assign rxPop    = accessPh && !pwrite && !pslverr
                    && paddr == ssp_pkg::DATA_OFS;

  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    unique case (paddr)
      ssp_pkg::CTRL0_OFS: rdMux[15:0] = ctrl0_r;
      ssp_pkg::CTRL1_OFS: rdMux[1:0]  = ctrl1_r;
      ssp_pkg::DATA_OFS:  rdMux[15:0] = rxHead;
      ssp_pkg::STAT_OFS:  rdMux[4:0]  = {state_r == ST_SHIFT, rxFull,
                                         !rxEmpty, !txFull, txEmpty};
      ssp_pkg::PRESC_OFS: rdMux[7:0]  = prescale_r;
      ssp_pkg::IMASK_OFS: rdMux[4:0]  = imask_r;
      ssp_pkg::RIS_OFS:   rdMux[4:0]  = raw;
      ssp_pkg::MIS_OFS:   rdMux[4:0]  = masked;
      ssp_pkg::ICR_OFS:   rdMux       = 32'h0000_0000;
      ssp_pkg::DMA_OFS:   rdMux[1:0]  = dmaCtl_r;
      default:            mapped      = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupPh;
      pslverr <= setupPh && !mapped;
      if (setupPh) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl0_r    <= ssp_pkg::CTRL0_RST;
      ctrl1_r    <= ssp_pkg::CTRL1_RST;
      prescale_r <= ssp_pkg::PRESC_RST;
      imask_r    <= ssp_pkg::IMASK_RST;
      dmaCtl_r   <= ssp_pkg::DMA_RST;
    end else if (wrEn) begin
      unique case (paddr)
        ssp_pkg::CTRL0_OFS: ctrl0_r    <= pwdata[15:0];
        ssp_pkg::CTRL1_OFS: ctrl1_r    <= pwdata[1:0];
        ssp_pkg::PRESC_OFS: prescale_r <= {pwdata[7:1], 1'b0};
        ssp_pkg::IMASK_OFS: imask_r    <= pwdata[4:0];
        ssp_pkg::DMA_OFS:   dmaCtl_r   <= pwdata[1:0];
        default:            ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit-rate divider, runs free so time-out counts while idle
  // half period = (prescale / 2) * (1 + rate factor) system clocks
  assign preHalf  = (prescale_r[7:1] == 7'h00) ? 7'h01 : prescale_r[7:1];
  assign preTick  = preCnt_r == preHalf - 7'h01;
  assign halfTick = preTick && rateCnt_r == ctrl0_r.serialRateFactor;
  assign bitTick  = halfTick && halfPhase_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      preCnt_r    <= 7'h00;
      rateCnt_r   <= 8'h00;
      halfPhase_r <= 1'b0;
    end else begin
      preCnt_r <= preTick ? 7'h00 : preCnt_r + 7'h01;
      if (halfTick) begin
        rateCnt_r   <= 8'h00;
        halfPhase_r <= !halfPhase_r;
      end else if (preTick) begin
        rateCnt_r <= rateCnt_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclkSync_r <= 2'h0;
      frmSync_r  <= 2'h3;
      rxdSync_r  <= 2'h0;
      sclkPrev_r <= 1'b0;
      frmPrev_r  <= 1'b1;
    end else begin
      sclkSync_r <= {sclkSync_r[0], serialBitClockIn};
      frmSync_r  <= {frmSync_r[0], frameIn};
      rxdSync_r  <= {rxdSync_r[0], serialInLine};
      sclkPrev_r <= sclkSync_r[1];
      frmPrev_r  <= frmSync_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine decode
  assign enabled = ctrl1_r[ssp_pkg::C1_EN_BIT];
  assign isSlave = ctrl1_r[ssp_pkg::C1_SLAVE_BIT];
  assign sizeM1  = (ctrl0_r.sizeM1 < ssp_pkg::MIN_SIZE_M1)
                   ? ssp_pkg::MIN_SIZE_M1 : ctrl0_r.sizeM1;
  // frame-pulse format always launches on the leading edge
  assign cpha    = (ctrl0_r.fmt == ssp_pkg::FMT_SSF) ? 1'b1 : ctrl0_r.sph;
  assign idleClk = (ctrl0_r.fmt == ssp_pkg::FMT_SSF) ? 1'b0 : ctrl0_r.spo;
  assign sizeMask = 16'hFFFF >> (4'hF - sizeM1);

  // slave start: select falls in spi, frame pulse rises otherwise
  assign slaveStart  = enabled && isSlave && state_r == ST_IDLE
                       && ((ctrl0_r.fmt == ssp_pkg::FMT_SSF)
                           ? (frmSync_r[1] && !frmPrev_r)
                           : (!frmSync_r[1] && frmPrev_r));
  assign masterStart = enabled && !isSlave && state_r == ST_IDLE
                       && !txEmpty && halfTick;
  assign startEv     = slaveStart || masterStart;
  // spi slave drops the frame if select is released early
  assign slaveAbort  = isSlave && ctrl0_r.fmt != ssp_pkg::FMT_SSF
                       && frmSync_r[1];

  assign edgeEv   = state_r == ST_SHIFT
                    && (isSlave ? (sclkSync_r[1] != sclkPrev_r) : halfTick);
  assign sampleEv = edgeEv && edgeCnt_r[0] == cpha;
  assign shiftEv  = edgeEv && edgeCnt_r[0] != cpha && edgeCnt_r != 5'h00;
  assign lastEdge = edgeCnt_r == {sizeM1, 1'b1};
  assign frameDone = edgeEv && lastEdge;

  // slave sends stale history when nothing is queued
  assign loadWord = (txEmpty ? txStale : txHead) & sizeMask;
  assign txPop    = startEv && !txEmpty;
  // last sample can land on the final edge, so merge it in
  assign rxWord   = (sampleEv ? {rxShift_r[14:0], rxdSync_r[1]}
                              : rxShift_r) & sizeMask;
  assign rxPush   = frameDone && !rxFull;

  ////////////////////////////////////////////////////////////////////////////
  // frame state
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      edgeCnt_r <= 5'h00;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          edgeCnt_r <= 5'h00;
          if (startEv) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!enabled || (frameDone) || slaveAbort) begin
            state_r <= ST_IDLE;
          end else if (edgeEv) begin
            edgeCnt_r <= edgeCnt_r + 5'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift registers, msb first
  always_ff @(posedge mclk) begin
    if (rst) begin
      txShift_r     <= 16'h0000;
      rxShift_r     <= 16'h0000;
      serialOutLine <= 1'b0;
    end else if (startEv) begin
      txShift_r     <= loadWord;
      rxShift_r     <= 16'h0000;
      serialOutLine <= loadWord[sizeM1];
    end else begin
      if (shiftEv) begin
        txShift_r     <= txShift_r << 1;
        serialOutLine <= txShift_r[sizeM1 - 4'h1];
      end
      if (sampleEv) begin
        rxShift_r <= {rxShift_r[14:0], rxdSync_r[1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master clock and frame pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      serialBitClockOut <= 1'b0;
      frameOut          <= 1'b1;
      serialOutEnN      <= 1'b1;
    end else begin
      serialOutEnN <= !(enabled && (!isSlave || state_r == ST_SHIFT));
      if (isSlave || state_r == ST_IDLE || !enabled) begin
        serialBitClockOut <= idleClk;
      end else if (edgeEv && !lastEdge) begin
        serialBitClockOut <= !serialBitClockOut;
      end else if (frameDone) begin
        serialBitClockOut <= idleClk;
      end
      if (ctrl0_r.fmt == ssp_pkg::FMT_SSF) begin
        // pulse spans the first bit period only
        frameOut <= masterStart
                    || (frameOut && state_r == ST_SHIFT
                        && !(edgeEv && edgeCnt_r == 5'h01));
      end else begin
        frameOut <= !((masterStart || state_r == ST_SHIFT)
                      && !frameDone && !isSlave && enabled);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status sources, set wins over software clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      rtCnt_r  <= 6'h00;
      rtRaw_r  <= 1'b0;
      rorRaw_r <= 1'b0;
      eotRaw_r <= 1'b0;
    end else begin
      if (rxEmpty) begin
        rtCnt_r <= 6'h00;
      end else if (bitTick && rtCnt_r != ssp_pkg::TIMEOUT_BITS) begin
        rtCnt_r <= rtCnt_r + 6'h01;
      end
      if (!rxEmpty && bitTick
          && rtCnt_r == ssp_pkg::TIMEOUT_BITS - 6'h01) begin
        rtRaw_r <= 1'b1;
      end else if (wrEn && paddr == ssp_pkg::ICR_OFS && pwdata[2]) begin
        rtRaw_r <= 1'b0;
      end
      if (frameDone && rxFull) begin
        rorRaw_r <= 1'b1;
      end else if (wrEn && paddr == ssp_pkg::ICR_OFS && pwdata[3]) begin
        rorRaw_r <= 1'b0;
      end
      if (frameDone && txEmpty) begin
        eotRaw_r <= 1'b1;
      end else if (wrEn && paddr == ssp_pkg::ICR_OFS && pwdata[4]) begin
        eotRaw_r <= 1'b0;
      end
    end
  end

  assign raw.txs = txCount <= ssp_pkg::HALF_LVL;
  assign raw.rxs = rxCount >= ssp_pkg::HALF_LVL;
  assign raw.rt  = rtRaw_r;
  assign raw.ror = rorRaw_r;
  assign raw.end_of_transmission = eotRaw_r;
  assign masked  = raw & imask_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and dma outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqCombined  <= 1'b0;
      irqTxService <= 1'b0;
      irqRxService <= 1'b0;
      irqStatus    <= 1'b0;
      txDmaReq     <= 1'b0;
      rxDmaReq     <= 1'b0;
    end else begin
      irqCombined  <= |masked;
      irqTxService <= masked.txs;
      irqRxService <= masked.rxs;
      irqStatus    <= masked.rt || masked.ror || masked.end_of_transmission;
      // empty-ish transmit fifo may request dma as well as interrupt
      txDmaReq     <= dmaCtl_r[ssp_pkg::DMA_TX_BIT]
                      && raw.txs;
      rxDmaReq     <= dmaCtl_r[ssp_pkg::DMA_RX_BIT]
                      && !rxEmpty;
    end
  end

endmodule : ssp_serial_port

/* logic/ssp_pkg.sv */
// ssp_pkg: register map, field layouts, reset values and types of the
// synchronous serial port.
// assumes: shared by the port top and its fifo; no other dependency.
package ssp_pkg;

  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W      = 3;
  localparam int CNT_W      = 4;
  localparam int ADDR_W     = 8;

  // byte addresses of the register words
  localparam logic [ADDR_W-1:0] CTRL0_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL1_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] DATA_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] STAT_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] PRESC_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] IMASK_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] RIS_OFS   = 8'h18;
  localparam logic [ADDR_W-1:0] MIS_OFS   = 8'h1C;
  localparam logic [ADDR_W-1:0] ICR_OFS   = 8'h20;
  localparam logic [ADDR_W-1:0] DMA_OFS   = 8'h24;

  // control_register_one bits
  localparam int C1_EN_BIT    = 0;
  localparam int C1_SLAVE_BIT = 1;
  // dma_control_register bits
  localparam int DMA_RX_BIT   = 0;
  localparam int DMA_TX_BIT   = 1;

  // reset values
  localparam logic [15:0] CTRL0_RST = 16'h0003;
  localparam logic [1:0]  CTRL1_RST = 2'h0;
  localparam logic [7:0]  PRESC_RST = 8'h02;
  localparam logic [4:0]  IMASK_RST = 5'h00;
  localparam logic [1:0]  DMA_RST   = 2'h0;

  // frame size limits, fifo trigger level, time-out length
  localparam logic [3:0]  MIN_SIZE_M1  = 4'h3;
  localparam logic [CNT_W-1:0] HALF_LVL = 4'h4;
  localparam logic [5:0]  TIMEOUT_BITS = 6'h20;

  // frame formats
  localparam logic [1:0]  FMT_SPI = 2'h0;
  localparam logic [1:0]  FMT_SSF = 2'h1;

  // control_register_zero layout, bit 15 downward
  typedef struct packed {
    logic [7:0] serialRateFactor;
    logic       sph;
    logic       spo;
    logic [1:0] fmt;
    logic [3:0] sizeM1;
  } ssp_ctrl0_t;

  // interrupt sources, bit 4 downward
  typedef struct packed {
    logic end_of_transmission;
    logic ror;
    logic rt;
    logic rxs;
    logic txs;
  } ssp_irq_t;

endpackage : ssp_pkg

/* logic/ssp_fifo.sv */
// ssp_fifo: 16-bit by 8-entry first-in first-out store.
// assumes: push when full and pop when empty are ignored here.
`timescale 1ns/10ps
module ssp_fifo (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // fill side
  input  wire logic                         push,
  input  wire logic [ssp_pkg::DATA_W-1:0]   pushData,
  // drain side
  input  wire logic                         pop,
  output logic      [ssp_pkg::DATA_W-1:0]   headData,
  // state
  output logic      [ssp_pkg::CNT_W-1:0]    count,
  output logic                              full,
  output logic                              empty,
  output logic      [ssp_pkg::DATA_W-1:0]   staleWord
);

  logic [ssp_pkg::DATA_W-1:0] mem [ssp_pkg::FIFO_DEPTH];
  logic [ssp_pkg::PTR_W-1:0]  wPtr_r;
  logic [ssp_pkg::PTR_W-1:0]  rPtr_r;
  logic [ssp_pkg::CNT_W-1:0]  count_r;
  logic                       doPush;
  logic                       doPop;

  assign doPush = push && !full;
  assign doPop  = pop && !empty;

  ////////////////////////////////////////////////////////////////////////////
  // storage, cleared so unwritten slots read zero
  genvar gi;
  generate
    for (gi = 0; gi < ssp_pkg::FIFO_DEPTH; gi++) begin : g_entry
      always_ff @(posedge mclk) begin
        if (rst) begin
          mem[gi] <= 16'h0000;
        end else if (doPush && wPtr_r == 3'(gi)) begin
          mem[gi] <= pushData;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (rst) begin
      wPtr_r  <= 3'h0;
      rPtr_r  <= 3'h0;
      count_r <= 4'h0;
    end else begin
      if (doPush) begin
        wPtr_r <= wPtr_r + 3'h1;
      end
      if (doPop) begin
        rPtr_r <= rPtr_r + 3'h1;
      end
      if (doPush && !doPop) begin
        count_r <= count_r + 4'h1;
      end else if (doPop && !doPush) begin
        count_r <= count_r - 4'h1;
      end
    end
  end

  assign headData  = mem[rPtr_r];
  assign count     = count_r;
  assign full      = count_r == 4'h8;
  assign empty     = count_r == 4'h0;
  // slot about to be overwritten holds the eighth most recent write
  assign staleWord = mem[wPtr_r];

endmodule : ssp_fifo

/* testbench/ssp_serial_port_asserts.sv */
// ssp_serial_port_asserts: port-level checks of the serial port.
// assumes: bound to ssp_serial_port; one clock, synchronous reset.
`timescale 1ns/10ps
module ssp_serial_port_asserts (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial and events
  input wire logic        serialBitClockOut,
  input wire logic        serialOutEnN,
  input wire logic        irqCombined,
  input wire logic        irqTxService,
  input wire logic        irqRxService,
  input wire logic        txDmaReq,
  input wire logic        rxDmaReq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // mirror of the dma enables, taken at the apb completion edge
  logic [1:0] dmaEn_r;
  always_ff @(posedge mclk) begin
    if (rst)
      dmaEn_r <= 2'h0;
    else if (psel && penable && pready && pwrite &&
             paddr == ssp_pkg::DMA_OFS)
      dmaEn_r <= pwdata[1:0];
  end
  ////////////////////////////////////////////////////////////////////////
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no ready after setup");
  property p_ready_src; pready |-> $past(psel) && !$past(penable);
  endproperty
  a_ready_src: assert property (p_ready_src)
    else $error("ready without setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_reset_quiet;
    $fell(rst) |-> !irqCombined && !txDmaReq && !rxDmaReq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("request active after reset");
  property p_comb_or; irqTxService || irqRxService |-> irqCombined;
  endproperty
  a_comb_or: assert property (p_comb_or)
    else $error("combined request missing");
  property p_clk_idle;
    serialOutEnN && $past(serialOutEnN) |-> $stable(serialBitClockOut);
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("serial clock moved while idle");
  property p_tx_dma; !dmaEn_r[1] && !$past(dmaEn_r[1]) |-> !txDmaReq;
  endproperty
  a_tx_dma: assert property (p_tx_dma)
    else $error("tx dma without enable");
  property p_rx_dma; !dmaEn_r[0] && !$past(dmaEn_r[0]) |-> !rxDmaReq;
  endproperty
  a_rx_dma: assert property (p_rx_dma)
    else $error("rx dma without enable");
endmodule : ssp_serial_port_asserts

bind ssp_serial_port ssp_serial_port_asserts i_ssp_serial_port_asserts (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .serialBitClockOut(serialBitClockOut), .serialOutEnN(serialOutEnN),
  .irqCombined(irqCombined), .irqTxService(irqTxService),
  .irqRxService(irqRxService), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq));

/* testbench/ssp_spi_slave_model.sv */
// ssp_spi_slave_model: far-side spi slave, clock idles low, msb first.
// assumes: select low per frame; reply word is 0xC3 plus frame index.
`timescale 1ns/10ps
module ssp_spi_slave_model #(
  parameter int SIZE = 8
) (
  input  wire logic sclk,
  input  wire logic selN,
  input  wire logic mosi,
  output logic      miso
);
  logic [15:0] rxSh = 16'h0;
  logic [15:0] txSh = 16'h00C3;
  logic [15:0] got [0:15];
  int          nFrm = 0;
  int          nBit = 0;
  initial miso = 1'b0;
  always @(negedge selN) miso = txSh[SIZE-1];
  always @(posedge sclk) begin
    if (!selN) begin
      rxSh = {rxSh[14:0], mosi};
      nBit++;
      if (nBit == SIZE) begin
        got[nFrm] = rxSh & ~(16'hFFFF << SIZE);
        nFrm++;
        nBit = 0;
        txSh = 16'h00C3 + 16'(nFrm);
      end
    end
  end
  always @(negedge sclk) if (!selN) miso = txSh[SIZE-1-nBit];
  // released line: no stale level for the master to pick up
  always @(posedge selN) miso = ~miso;
endmodule : ssp_spi_slave_model

/* testbench/tb_ssp_serial_port.sv */
// tb_ssp_serial_port: self-checking bench, master spi mode.
// assumes: slave model on the pins, checker bound in its own file.
`timescale 1ns/10ps
module tb_ssp_serial_port;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, sclk, selN, mosi, enN, miso;
  logic        irqC, irqT, irqR, irqS, dmaT, dmaR;
  int          n_errors = 0, tests_run = 0, cyc = 0;
  ssp_serial_port i_ssp_serial_port (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialBitClockOut(sclk),
    .serialBitClockIn(1'b0), .frameOut(selN), .frameIn(1'b1),
    .serialOutLine(mosi), .serialOutEnN(enN), .serialInLine(miso),
    .irqCombined(irqC), .irqTxService(irqT), .irqRxService(irqR),
    .irqStatus(irqS), .txDmaReq(dmaT), .rxDmaReq(dmaR));
  ssp_spi_slave_model #(.SIZE(8)) i_ssp_spi_slave_model (
    .sclk(sclk), .selN(selN), .mosi(mosi), .miso(miso));
  initial begin forever #5 mclk = ~mclk; end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wait_eot;
    q = 32'h0;
    while (q[4] !== 1'b1) apb(1'b0, ssp_pkg::RIS_OFS, 32'h0);
  endtask : wait_eot
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(1'b0, ssp_pkg::IMASK_OFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, ssp_pkg::DMA_OFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, ssp_pkg::STAT_OFS, 32'h0);
    chk(q, 32'h3);
    apb(1'b0, ssp_pkg::RIS_OFS, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk({q[30:0], err}, 32'h1);
    $display("reset test done");
  endtask : t_reset
  // port held off so the tx fifo fills; the ninth word must be dropped
  task automatic t_fill;
    apb(1'b1, ssp_pkg::CTRL0_OFS, 32'h0107);
    apb(1'b1, ssp_pkg::PRESC_OFS, 32'h4);
    apb(1'b1, ssp_pkg::DMA_OFS, 32'h2);
    for (int i = 0; i < 9; i++) apb(1'b1, ssp_pkg::DATA_OFS, 32'h90 + i);
    apb(1'b0, ssp_pkg::STAT_OFS, 32'h0);
    chk(q, 32'h0);
    chk(32'(dmaT), 32'h0);
    $display("fill test done");
  endtask : t_fill
  task automatic t_run;
    apb(1'b1, ssp_pkg::CTRL1_OFS, 32'h1);
    wait_eot();
    apb(1'b0, ssp_pkg::STAT_OFS, 32'h0);
    chk(q, 32'hF);
    chk(32'({dmaT, dmaR}), 32'h2);
    apb(1'b0, ssp_pkg::RIS_OFS, 32'h0);
    chk(32'(q[4:2]), 32'h5);
    apb(1'b1, ssp_pkg::ICR_OFS, 32'h1C);
    apb(1'b1, ssp_pkg::DATA_OFS, 32'hA0);
    wait_eot();
    chk(32'(q[3]), 32'h1);
    chk(32'(i_ssp_spi_slave_model.nFrm), 32'h9);
    for (int i = 0; i < 9; i++)
      chk(32'(i_ssp_spi_slave_model.got[i]),
          i < 8 ? 32'h90 + i : 32'hA0);
    $display("run test done");
  endtask : t_run
  task automatic t_irq;
    apb(1'b1, ssp_pkg::IMASK_OFS, 32'h2);
    apb(1'b1, ssp_pkg::DMA_OFS, 32'h1);
    @(posedge mclk);
    chk(32'({irqC, irqT, irqR, irqS, dmaT, dmaR}), 32'h29);
    apb(1'b0, ssp_pkg::MIS_OFS, 32'h0);
    chk(q, 32'h2);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ssp_pkg::DATA_OFS, 32'h0);
      chk(q, 32'hC3 + i);
    end
    @(posedge mclk);
    chk(32'({irqC, irqR, dmaR}), 32'h0);
    $display("irq test done");
  endtask : t_irq
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_fill();
    t_run();
    t_irq();
    end_of_test();
  end
endmodule : tb_ssp_serial_port
